// ==== core/brk_device.sv ====
// breakpoint unit: address compare, break flags and low-power exit status
`timescale 1ns/1ps
module brk_device (
  input  wire logic clk,
  input  wire logic resetn,
  brk_if.device     link
);
  import brk_pkg::*;

  typedef struct packed {
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic       match_break_enable;
    logic       break_active_flag;
    logic       lowpower_exit_by_break_flag;
    logic       flag_clear_in_break_enable;
    logic       in_break;
    logic [7:0] rdata;
    logic       request;
    logic       wake;
    logic       timer_halt;
    logic       wd_disable;
    logic       clear_allowed;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic [15:0] bp_addr;
  logic        match;
  logic        low_power;
  logic        w_ctrl;

  always_comb
  begin
    st_nxt    = st_r;
    bp_addr   = {st_r.addr_high, st_r.addr_low};
    low_power = link.in_wait | link.in_stop;
    w_ctrl    = link.reg_write && link.reg_addr == bp_ctrl_status_addr;
    // compare stays live in wait mode so a break can end it
    match     = st_r.match_break_enable && link.cpu_addr == bp_addr;
    if (link.reg_write)
    begin
      case (link.reg_addr)
        bp_addr_high_addr:    st_nxt.addr_high = link.reg_wdata;
        bp_addr_low_addr:     st_nxt.addr_low  = link.reg_wdata;
        bp_ctrl_status_addr:
        begin
          st_nxt.match_break_enable = link.reg_wdata[match_enable_bit];
          st_nxt.break_active_flag  = link.reg_wdata[break_active_bit];
        end
        lowpower_status_addr:
          if (!link.reg_wdata[lowpower_exit_bit])
            st_nxt.lowpower_exit_by_break_flag = 1'b0;
        flag_clear_ctrl_addr:
          st_nxt.flag_clear_in_break_enable = link.reg_wdata[clear_enable_bit];
        default: ;
      endcase
    end
    if (match)
      st_nxt.break_active_flag = 1'b1;
    st_nxt.request = match || (w_ctrl && link.reg_wdata[break_active_bit]);
    st_nxt.wake = 1'b0;
    if (st_nxt.request && low_power)
    begin
      st_nxt.wake = 1'b1;
      st_nxt.lowpower_exit_by_break_flag = 1'b1;
    end
    if (st_r.request)
      st_nxt.in_break = 1'b1;
    if (link.return_done)
      st_nxt.in_break = 1'b0;
    st_nxt.timer_halt    = st_nxt.in_break;
    st_nxt.wd_disable    = st_nxt.in_break && link.rst_pin_at_vtst;
    st_nxt.clear_allowed = !st_nxt.in_break || st_nxt.flag_clear_in_break_enable;
    st_nxt.rdata = 8'h00;
    if (link.reg_read)
    begin
      case (link.reg_addr)
        bp_addr_high_addr:    st_nxt.rdata = st_r.addr_high;
        bp_addr_low_addr:     st_nxt.rdata = st_r.addr_low;
        bp_ctrl_status_addr:
        begin
          st_nxt.rdata[match_enable_bit] = st_r.match_break_enable;
          st_nxt.rdata[break_active_bit] = st_r.break_active_flag;
        end
        lowpower_status_addr:
          st_nxt.rdata[lowpower_exit_bit] = st_r.lowpower_exit_by_break_flag;
        flag_clear_ctrl_addr:
          st_nxt.rdata[clear_enable_bit] = st_r.flag_clear_in_break_enable;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r               <= '0;
      st_r.clear_allowed <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign link.reg_rdata          = st_r.rdata;
  assign link.break_request      = st_r.request;
  assign link.break_state        = st_r.in_break;
  assign link.lowpower_wake      = st_r.wake;
  assign link.timer_halt         = st_r.timer_halt;
  assign link.watchdog_disable   = st_r.wd_disable;
  assign link.flag_clear_allowed = st_r.clear_allowed;
endmodule : brk_device

// ==== core/brk_flag_cell.sv ====
// sticky event bit: hardware set wins over a write-one clear
`timescale 1ns/1ps
module brk_flag_cell (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag
);
  typedef struct packed {
    logic flag;
  } state_type;
  state_type st_r;
  state_type st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    if (clear_pulse)
      st_nxt.flag = 1'b0;
    if (set_pulse)
      st_nxt.flag = 1'b1;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign flag = st_r.flag;
endmodule : brk_flag_cell

// ==== core/brk_host.sv ====
// cpu-side controller: drives the unit's bus and runs break entry and return
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module brk_host (
  input  wire logic  clk,
  input  wire logic  resetn,
  brk_if.host        link,
  input  wire logic [2:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic  sw_write,
  input  wire logic  sw_read,
  output logic [7:0] sw_rdata,
  output logic       irq,
  output logic [15:0] vector_addr,
  output logic [7:0] instr_reg
);
  import brk_pkg::*;

  typedef enum logic [1:0] {run, finishing, in_break} phase_type;

  typedef struct packed {
    phase_type   phase;
    logic [7:0]  mask;
    logic [7:0]  cmd;
    logic [15:0] pc;
    logic [15:0] bus_addr;
    logic [7:0]  bus_data;
    logic        bus_write;
    logic        bus_read;
    logic        read_pending;
    logic        return_pulse;
    logic [7:0]  rdata;
    logic        irq;
    logic [15:0] vector;
    logic [7:0]  ir;
  } state_type;

  state_type  st_r;
  state_type  st_nxt;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic [3:0] status;
  logic       bus_busy;

  // one sticky cell per controller event
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ev
      brk_flag_cell u_cell (
        .clk         (clk),
        .resetn      (resetn),
        .set_pulse   (ev_set[gi]),
        .clear_pulse (ev_clr[gi]),
        .flag        (status[gi])
      );
    end
  endgenerate

  always_comb
  begin
    st_nxt       = st_r;
    ev_set       = '0;
    ev_clr       = '0;
    st_nxt.bus_write    = 1'b0;
    st_nxt.bus_read     = 1'b0;
    st_nxt.return_pulse = 1'b0;
    st_nxt.read_pending = st_r.bus_read;
    // a read still in flight would let its data overwrite a newer command
    bus_busy = st_r.bus_write | st_r.bus_read | st_r.read_pending;

    // link read data is taken in the one cycle it stands
    if (st_r.read_pending)
    begin
      st_nxt.bus_data = link.reg_rdata;
      ev_set[ev_bus_done_bit] = 1'b1;
    end
    if (st_r.bus_write)
      ev_set[ev_bus_done_bit] = 1'b1;

    if (sw_write)
    begin
      case (sw_addr)
        ctl_status_addr:        ev_clr = sw_wdata[3:0];
        ctl_mask_addr:          st_nxt.mask = sw_wdata;
        ctl_cmd_addr:
        begin
          st_nxt.cmd       = sw_wdata;
          // one link strobe at a time, a write winning over a read
          st_nxt.bus_write = sw_wdata[cmd_bus_write_bit] && !bus_busy;
          st_nxt.bus_read  = sw_wdata[cmd_bus_read_bit] && !sw_wdata[cmd_bus_write_bit]
                             && !bus_busy;
          // a return is only meaningful inside the break routine
          st_nxt.return_pulse = sw_wdata[cmd_return_bit] && st_r.phase == in_break;
        end
        ctl_pc_high_addr:       st_nxt.pc[15:8] = sw_wdata;
        ctl_pc_low_addr:        st_nxt.pc[7:0]  = sw_wdata;
        ctl_bus_addr_high_addr: st_nxt.bus_addr[15:8] = sw_wdata;
        ctl_bus_addr_low_addr:  st_nxt.bus_addr[7:0]  = sw_wdata;
        ctl_bus_data_addr:      st_nxt.bus_data = sw_wdata;
        default: ;
      endcase
    end

    // a request waits out the instruction unless it came on its last cycle
    case (st_r.phase)
      run:
        if (link.break_request)
        begin
          // a match on the last cycle needs no further instruction
          if (st_r.cmd[cmd_last_cycle_bit])
            st_nxt.phase = in_break;
          else
            st_nxt.phase = finishing;
        end
      finishing:
        // one cycle stands for the rest of the current instruction
        st_nxt.phase = in_break;
      in_break:
        if (st_r.return_pulse)
        begin
          st_nxt.phase = run;
          ev_set[ev_break_end_bit] = 1'b1;
        end
      default: st_nxt.phase = run;
    endcase

    // opcode and vector load once on entry, not on every cycle in break
    if (st_nxt.phase == in_break && st_r.phase != in_break)
    begin
      st_nxt.ir = software_interrupt_opcode;
      if (st_r.cmd[cmd_monitor_bit])
        st_nxt.vector = monitor_break_vector;
      else
        st_nxt.vector = break_vector;
      ev_set[ev_break_start_bit] = 1'b1;
    end

    // a wake ends wait or stop; rewinding the return address is up to software
    if (link.lowpower_wake)
    begin
      st_nxt.cmd[cmd_wait_bit] = 1'b0;
      st_nxt.cmd[cmd_stop_bit] = 1'b0;
      ev_set[ev_lowpower_exit_bit] = 1'b1;
    end

    st_nxt.rdata = 8'h00;
    if (sw_read)
    begin
      case (sw_addr)
        ctl_status_addr:        st_nxt.rdata = {4'h0, status};
        ctl_mask_addr:          st_nxt.rdata = st_r.mask;
        ctl_cmd_addr:           st_nxt.rdata = {st_r.cmd[7:4], 1'b0, st_r.cmd[2], 2'b00};
        ctl_pc_high_addr:       st_nxt.rdata = st_r.pc[15:8];
        ctl_pc_low_addr:        st_nxt.rdata = st_r.pc[7:0];
        ctl_bus_addr_high_addr: st_nxt.rdata = st_r.bus_addr[15:8];
        ctl_bus_addr_low_addr:  st_nxt.rdata = st_r.bus_addr[7:0];
        ctl_bus_data_addr:      st_nxt.rdata = st_r.bus_data;
        default: ;
      endcase
    end

    // irq lags the status bits by a cycle so that the pin stays a flop
    st_nxt.irq = |(status & st_r.mask[3:0]);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // the program counter serves as the cpu-generated address
  assign link.cpu_addr         = st_r.pc;
  assign link.instr_last_cycle = st_r.cmd[cmd_last_cycle_bit];
  assign link.reg_write        = st_r.bus_write;
  assign link.reg_read         = st_r.bus_read;
  assign link.reg_addr         = st_r.bus_addr;
  assign link.reg_wdata        = st_r.bus_data;
  assign link.in_wait          = st_r.cmd[cmd_wait_bit];
  assign link.in_stop          = st_r.cmd[cmd_stop_bit];
  assign link.rst_pin_at_vtst  = st_r.cmd[cmd_vtst_bit];
  assign link.return_done      = st_r.return_pulse;

  assign sw_rdata              = st_r.rdata;
  assign irq                   = st_r.irq;
  assign vector_addr           = st_r.vector;
  assign instr_reg             = st_r.ir;
endmodule : brk_host

// ==== core/brk_if.sv ====
// interface between the breakpoint unit and the cpu sequencing logic
`timescale 1ns/1ps
interface brk_if;
  logic [15:0] cpu_addr;
  logic        instr_last_cycle;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        in_wait;
  logic        in_stop;
  logic        rst_pin_at_vtst;
  logic        return_done;
  logic        break_request;
  logic        break_state;
  logic        lowpower_wake;
  logic        timer_halt;
  logic        watchdog_disable;
  logic        flag_clear_allowed;
  modport device (
    input  cpu_addr, instr_last_cycle, reg_write, reg_read, reg_addr, reg_wdata,
    input  in_wait, in_stop, rst_pin_at_vtst, return_done,
    output reg_rdata, break_request, break_state, lowpower_wake, timer_halt,
    output watchdog_disable, flag_clear_allowed
  );
  modport host (
    output cpu_addr, instr_last_cycle, reg_write, reg_read, reg_addr, reg_wdata,
    output in_wait, in_stop, rst_pin_at_vtst, return_done,
    input  reg_rdata, break_request, break_state, lowpower_wake, timer_halt,
    input  watchdog_disable, flag_clear_allowed
  );
endinterface : brk_if

// ==== core/brk_pkg.sv ====
// package: register map, field positions and reset values of the breakpoint unit
package brk_pkg;
  localparam logic [15:0] lowpower_status_addr   = 16'hfe00;
  localparam logic [15:0] flag_clear_ctrl_addr   = 16'hfe03;
  localparam logic [15:0] bp_addr_high_addr      = 16'hfe0c;
  localparam logic [15:0] bp_addr_low_addr       = 16'hfe0d;
  localparam logic [15:0] bp_ctrl_status_addr    = 16'hfe0e;
  localparam int          match_enable_bit       = 7;
  localparam int          break_active_bit       = 6;
  localparam int          lowpower_exit_bit      = 1;
  localparam int          clear_enable_bit       = 7;
  localparam logic [7:0]  byte_reset             = 8'h00;
  // controller registers on the software port
  localparam logic [2:0]  ctl_status_addr        = 3'h0;
  localparam logic [2:0]  ctl_mask_addr          = 3'h1;
  localparam logic [2:0]  ctl_cmd_addr           = 3'h2;
  localparam logic [2:0]  ctl_pc_high_addr       = 3'h3;
  localparam logic [2:0]  ctl_pc_low_addr        = 3'h4;
  localparam logic [2:0]  ctl_bus_addr_high_addr = 3'h5;
  localparam logic [2:0]  ctl_bus_addr_low_addr  = 3'h6;
  localparam logic [2:0]  ctl_bus_data_addr      = 3'h7;
  // status / mask bits of the controller
  localparam int          ev_break_start_bit     = 0;
  localparam int          ev_break_end_bit       = 1;
  localparam int          ev_lowpower_exit_bit   = 2;
  localparam int          ev_bus_done_bit        = 3;
  // command bits of the controller
  localparam int          cmd_bus_write_bit      = 0;
  localparam int          cmd_bus_read_bit       = 1;
  localparam int          cmd_last_cycle_bit     = 2;
  localparam int          cmd_return_bit         = 3;
  localparam int          cmd_wait_bit           = 4;
  localparam int          cmd_stop_bit           = 5;
  localparam int          cmd_vtst_bit           = 6;
  localparam int          cmd_monitor_bit        = 7;
  localparam logic [15:0] break_vector           = 16'hfffc;
  localparam logic [15:0] monitor_break_vector   = 16'hfefc;
  localparam logic [7:0]  software_interrupt_opcode = 8'h83;
endpackage : brk_pkg

// ==== verification/address_breakpoint_unit_test.sv ====
// self-checking bench: controller and breakpoint unit joined by their interface
`timescale 1ns/1ps
module address_breakpoint_unit_test;
  import brk_pkg::*;
  logic        clk;
  logic        resetn;
  logic [2:0]  sw_addr;
  logic [7:0]  sw_wdata;
  logic        sw_write;
  logic        sw_read;
  logic [7:0]  sw_rdata;
  logic        irq;
  logic [15:0] vector_addr;
  logic [7:0]  instr_reg;
  logic [7:0]  mode;
  int          err_count;
  int          compares;
  brk_if link ();
  brk_device i_brk_device (.clk(clk), .resetn(resetn), .link(link));
  brk_host i_brk_host (.clk(clk), .resetn(resetn), .link(link), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
    .irq(irq), .vector_addr(vector_addr), .instr_reg(instr_reg));
  brk_asserts i_brk_asserts (.clk(clk), .resetn(resetn), .cpu_addr(link.cpu_addr),
    .reg_write(link.reg_write), .reg_read(link.reg_read), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .in_stop(link.in_stop),
    .rst_pin_at_vtst(link.rst_pin_at_vtst), .return_done(link.return_done),
    .break_request(link.break_request), .break_state(link.break_state),
    .lowpower_wake(link.lowpower_wake), .timer_halt(link.timer_halt),
    .watchdog_disable(link.watchdog_disable), .flag_clear_allowed(link.flag_clear_allowed));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict;
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge clk);
    sw_write <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge clk);
    sw_read <= 1'b0;
    #1;
    check({8'h00, sw_rdata}, {8'h00, e});
  endtask : sw_rd
  // mode bits ride along so a bus command does not drop wait, stop or test voltage
  task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
    sw_wr(ctl_bus_addr_high_addr, a[15:8]);
    sw_wr(ctl_bus_addr_low_addr, a[7:0]);
    sw_wr(ctl_bus_data_addr, d);
    sw_wr(ctl_cmd_addr, mode | 8'h01);
    repeat (3) @(posedge clk);
  endtask : dev_wr
  task automatic dev_rd(input logic [15:0] a, input logic [7:0] e);
    sw_wr(ctl_bus_addr_high_addr, a[15:8]);
    sw_wr(ctl_bus_addr_low_addr, a[7:0]);
    sw_wr(ctl_cmd_addr, mode | 8'h02);
    repeat (3) @(posedge clk);
    sw_rd(ctl_bus_data_addr, e);
  endtask : dev_rd
  task automatic wait_state(input logic e);
    int n;
    n = 0;
    #1;
    while (link.break_state !== e && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({15'h0000, link.break_state}, {15'h0000, e});
  endtask : wait_state
  initial
  begin
    repeat (6000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial
  begin
    resetn   = 1'b0;
    sw_addr  = 3'h0;
    sw_wdata = 8'h00;
    sw_write = 1'b0;
    sw_read  = 1'b0;
    mode     = 8'h00;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    dev_rd(bp_addr_high_addr, 8'h00);
    dev_rd(bp_addr_low_addr, 8'h00);
    dev_rd(bp_ctrl_status_addr, 8'h00);
    dev_rd(lowpower_status_addr, 8'h00);
    dev_rd(flag_clear_ctrl_addr, 8'h00);
    dev_rd(16'hfe01, 8'h00);
    dev_wr(bp_addr_high_addr, 8'h12);
    dev_wr(bp_addr_low_addr, 8'h34);
    dev_rd(bp_addr_high_addr, 8'h12);
    dev_rd(bp_addr_low_addr, 8'h34);
    sw_wr(ctl_mask_addr, 8'h01);
    sw_wr(ctl_pc_high_addr, 8'h12);
    sw_wr(ctl_pc_low_addr, 8'h34);
    repeat (4) @(posedge clk);
    wait_state(1'b0);
    dev_wr(bp_ctrl_status_addr, 8'h80);
    wait_state(1'b1);
    sw_wr(ctl_pc_high_addr, 8'h00);
    check(vector_addr, break_vector);
    check({8'h00, instr_reg}, {8'h00, software_interrupt_opcode});
    dev_rd(bp_ctrl_status_addr, 8'hc0);
    check({15'h0000, irq}, 16'h0001);
    sw_rd(ctl_status_addr, 8'h09);
    sw_wr(ctl_status_addr, 8'hff);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0000);
    dev_wr(bp_ctrl_status_addr, 8'h80);
    dev_rd(bp_ctrl_status_addr, 8'h80);
    sw_wr(ctl_cmd_addr, 8'h08);
    wait_state(1'b0);
    sw_rd(ctl_status_addr, 8'h0a);
    mode = 8'hc0;
    sw_wr(ctl_cmd_addr, mode);
    dev_wr(bp_ctrl_status_addr, 8'h40);
    wait_state(1'b1);
    check(vector_addr, monitor_break_vector);
    check({15'h0000, link.timer_halt}, 16'h0001);
    check({15'h0000, link.watchdog_disable}, 16'h0001);
    check({15'h0000, link.flag_clear_allowed}, 16'h0000);
    dev_wr(flag_clear_ctrl_addr, 8'h80);
    check({15'h0000, link.flag_clear_allowed}, 16'h0001);
    dev_rd(flag_clear_ctrl_addr, 8'h80);
    dev_wr(bp_ctrl_status_addr, 8'h00);
    dev_rd(bp_ctrl_status_addr, 8'h00);
    sw_wr(ctl_cmd_addr, mode | 8'h08);
    wait_state(1'b0);
    for (int i = 0; i < 2; i++)
    begin
      mode = (i == 0) ? 8'h10 : 8'h20;
      sw_wr(ctl_cmd_addr, mode);
      dev_wr(bp_ctrl_status_addr, 8'h80);
      sw_wr(ctl_pc_low_addr, 8'h34);
      sw_wr(ctl_pc_high_addr, 8'h12);
      wait_state(1'b1);
      // the wake clears the low-power command bits
      mode = 8'h00;
      sw_wr(ctl_pc_high_addr, 8'h00);
      dev_rd(lowpower_status_addr, 8'h02);
      sw_wr(ctl_pc_low_addr, 8'h33);
      dev_wr(lowpower_status_addr, 8'h02);
      dev_rd(lowpower_status_addr, 8'h02);
      dev_wr(lowpower_status_addr, 8'h00);
      dev_rd(lowpower_status_addr, 8'h00);
      dev_wr(bp_ctrl_status_addr, 8'h00);
      sw_wr(ctl_cmd_addr, 8'h08);
      wait_state(1'b0);
    end
    // last-cycle request: the vector must load without the finishing cycle
    mode = 8'h84;
    sw_wr(ctl_bus_addr_high_addr, bp_ctrl_status_addr[15:8]);
    sw_wr(ctl_bus_addr_low_addr, bp_ctrl_status_addr[7:0]);
    sw_wr(ctl_bus_data_addr, 8'h40);
    sw_wr(ctl_cmd_addr, mode | 8'h01);
    repeat (2) @(posedge clk);
    #1;
    check(vector_addr, monitor_break_vector);
    wait_state(1'b1);
    dev_wr(bp_ctrl_status_addr, 8'h00);
    sw_wr(ctl_cmd_addr, 8'h08);
    wait_state(1'b0);
    give_verdict();
  end
endmodule : address_breakpoint_unit_test

// ==== verification/brk_asserts.sv ====
// assertions on the link between the breakpoint unit and the cpu controller
`timescale 1ns/1ps
module brk_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [15:0] cpu_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        in_stop,
  input wire logic        rst_pin_at_vtst,
  input wire logic        return_done,
  input wire logic        break_request,
  input wire logic        break_state,
  input wire logic        lowpower_wake,
  input wire logic        timer_halt,
  input wire logic        watchdog_disable,
  input wire logic        flag_clear_allowed
);
  import brk_pkg::*;
  logic [15:0] bp_r;
  logic        en_r;
  logic        cause_r;
  // shadow of the compare registers, so a request can be tied to its cause
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      bp_r    <= 16'h0000;
      en_r    <= 1'b0;
      cause_r <= 1'b0;
    end
    else
    begin
      cause_r <= (en_r && cpu_addr == bp_r) || (reg_write && reg_addr == bp_ctrl_status_addr
                 && reg_wdata[break_active_bit]);
      if (reg_write && reg_addr == bp_addr_high_addr)
        bp_r[15:8] <= reg_wdata;
      if (reg_write && reg_addr == bp_addr_low_addr)
        bp_r[7:0] <= reg_wdata;
      if (reg_write && reg_addr == bp_ctrl_status_addr)
        en_r <= reg_wdata[match_enable_bit];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_request; cause_r |-> break_request; endproperty
  property p_spurious; break_request |-> cause_r; endproperty
  property p_state; break_request |=> break_state; endproperty
  property p_timer; timer_halt == break_state; endproperty
  property p_wdog;
    (break_state && rst_pin_at_vtst && $past(break_state) && $past(rst_pin_at_vtst))
      |-> watchdog_disable;
  endproperty
  property p_return; (return_done && break_state && !break_request) |=> !break_state; endproperty
  property p_wake; lowpower_wake |-> break_request; endproperty
  property p_clear; !break_state |-> flag_clear_allowed; endproperty
  property p_rd_high; (reg_read && reg_addr == bp_addr_high_addr) |=> reg_rdata == bp_r[15:8];
  endproperty
  a_request: assert property (p_request) else $error("break request missing");
  a_spurious: assert property (p_spurious) else $error("break request without cause");
  a_state: assert property (p_state) else $error("break state not entered");
  a_timer: assert property (p_timer) else $error("timer halt differs from break");
  a_wdog: assert property (p_wdog) else $error("watchdog not disabled");
  a_return: assert property (p_return) else $error("break state not ended");
  a_wake: assert property (p_wake) else $error("wake without break");
  a_clear: assert property (p_clear) else $error("flag clear blocked outside break");
  a_rd_high: assert property (p_rd_high) else $error("address high byte wrong");
  c_break: cover property (break_request && !break_state);
  c_stop_wake: cover property (in_stop ##[1:3] lowpower_wake);
  c_wdog: cover property (watchdog_disable);
  c_return: cover property (return_done && break_state);
endmodule : brk_asserts
